// [mrc_defines.svh]
// mrc_defines.svh: register map, field positions, opcodes and timing counts
`ifndef MRC_DEFINES_SVH
`define MRC_DEFINES_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define MRC_OFF_CMD        8'h00
`define MRC_OFF_STAT       8'h04
`define MRC_OFF_CTRL       8'h08
`define MRC_OFF_RDATA      8'h0C

// ----------------------------------------
// field positions
// ----------------------------------------
`define MRC_CMD_MA_LSB     0
`define MRC_CMD_OP_LSB     8
`define MRC_CMD_KIND_LSB   16
`define MRC_CMD_ZQ_LSB     20
`define MRC_CMD_W          22
`define MRC_ST_ERR         1
`define MRC_CTL_X32        0
`define MRC_CTL_CKE_OFF    1
`define MRC_CTRL_RST       2'h1

// ----------------------------------------
// mode register addresses and opcodes
// ----------------------------------------
`define MRC_MA_PAT_A       8'h20
`define MRC_MA_PAT_B       8'h28
`define MRC_MA_ZQ          8'h0A
`define MRC_MA_RESET       8'h3F
`define MRC_OP_RESET       8'hFC
`define MRC_MA_TENTER      8'h29
`define MRC_OP_TENTER      8'hA4
`define MRC_MA_TREMAP      8'h30
`define MRC_OP_TREMAP      8'hC0
`define MRC_MA_TEXIT       8'h2A
`define MRC_OP_TEXIT       8'hA8

// ----------------------------------------
// timing
// ----------------------------------------
`define MRC_CLK_MHZ        40
`define MRC_CYC_UP(ns)     ((((ns) * `MRC_CLK_MHZ) + 999) / 1000)
`define MRC_TMRW_NS        10
`define MRC_TZQINIT_NS     1000
`define MRC_TZQCL_NS       360
`define MRC_TZQCS_NS       90
`define MRC_TMRW_CYC       `MRC_CYC_UP(`MRC_TMRW_NS)
`define MRC_TZQINIT_CYC    `MRC_CYC_UP(`MRC_TZQINIT_NS)
`define MRC_TZQCL_CYC      `MRC_CYC_UP(`MRC_TZQCL_NS)
`define MRC_TZQCS_CYC      `MRC_CYC_UP(`MRC_TZQCS_NS)
`define MRC_RD_LAT         4
`define MRC_BURST          8

`endif

// [mrc_pkg.sv]
// mrc_pkg.sv: types shared by the mode register controller
`default_nettype none
package mrc_pkg;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ZQARB = 7'h02,
    ST_ISSUE = 7'h04,
    ST_WAIT  = 7'h08,
    ST_ZQ    = 7'h10,
    ST_RDLAT = 7'h20,
    ST_CAPT  = 7'h40
  } mrc_state_t;

  typedef enum logic [2:0] {
    K_MRW    = 3'h0,
    K_MRR    = 3'h1,
    K_RESET  = 3'h2,
    K_ZQ     = 3'h3,
    K_TENTER = 3'h4,
    K_TREMAP = 3'h5,
    K_TEXIT  = 3'h6,
    K_TCAP   = 3'h7
  } mrc_kind_t;

  typedef enum logic [1:0] {
    TP_NONE     = 2'h0,
    TP_ENTERED  = 2'h1,
    TP_REMAPPED = 2'h2
  } mrc_tphase_t;

endpackage
`default_nettype wire

// [mrc_pat_chk.sv]
// mrc_pat_chk.sv: checks a calibration pattern burst on every byte lane when x32 is high, on lanes 0 and 1 only when it is low
`timescale 1ns/1ps
`default_nettype none
`include "mrc_defines.svh"
module mrc_pat_chk
  import mrc_pkg::*;
#(
  parameter int LANES = 4
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // burst beats
  input  wire logic               beat_vld,
  input  wire logic [2:0]         beat_idx,
  input  wire logic               pat_b,
  input  wire logic               x32,
  input  wire logic [8*LANES-1:0] dq,
  // result
  output logic                    ok,
  output logic                    done
);

  // pattern a alternates from 1, pattern b goes in pairs from 0
  function automatic logic exp_bit(input logic b, input logic [2:0] i);
    exp_bit = b ? i[1] : ~i[0];
  endfunction

  logic [LANES-1:0] lane_ok;
  logic             e;

  assign e = exp_bit(pat_b, beat_idx);

  // every bit of a lane must equal the expected pattern bit; lanes 2 and up pass when x32 is low
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign lane_ok[g] = (dq[8*g +: 8] == {8{e}}) || ((g >= 2) && !x32);
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ok   <= 1'b0;
      done <= 1'b0;
    end else if (beat_vld) begin
      ok   <= ((beat_idx == 3'h0) | ok) & (&lane_ok);
      done <= (beat_idx == 3'(`MRC_BURST - 1));
    end
  end

endmodule
`default_nettype wire

// [mrc_ctrl.sv]
// mrc_ctrl.sv: host-side mode register, zq and ca training command engine
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "mrc_defines.svh"
module mrc_ctrl
  import mrc_pkg::*;
#(
  parameter int RD_LAT = `MRC_RD_LAT,
  parameter int CNT_W  = 16
) (
  // ahb-lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // memory command/address pins
  output logic             cs_n,
  output logic             cke,
  output logic [9:0]       ca_rise,
  output logic [9:0]       ca_fall,
  // memory data pins, one beat per hclk from the phy
  input  wire logic [31:0] dq_in,
  // system
  input  wire logic        banks_idle,
  output logic             zq_req,
  input  wire logic        zq_gnt
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic is_cal(input logic [7:0] ma);
    is_cal = (ma == `MRC_MA_PAT_A) || (ma == `MRC_MA_PAT_B);
  endfunction

  function automatic logic is_rd(input mrc_kind_t k);
    is_rd = (k == K_MRR) || (k == K_TCAP);
  endfunction

  // legality of a new order against training phase and bank state
  function automatic logic cmd_ok(input mrc_kind_t k, input logic [7:0] ma,
                                  input mrc_tphase_t ph, input logic sess,
                                  input logic idle);
    if (ph != TP_NONE) begin
      case (k)
        K_TCAP:   cmd_ok = 1'b1;
        K_TREMAP: cmd_ok = (ph == TP_ENTERED) && sess;
        K_TEXIT:  cmd_ok = (ph == TP_REMAPPED) && sess;
        default:  cmd_ok = 1'b0;
      endcase
    end else begin
      case (k)
        K_MRR:                     cmd_ok = idle || !is_cal(ma);
        K_TCAP, K_TREMAP, K_TEXIT: cmd_ok = 1'b0;
        default:                   cmd_ok = idle;
      endcase
    end
  endfunction

  // fixed address, and fixed opcode for all but zq, for the dedicated orders, {op, ma}
  function automatic logic [15:0] fix_mo(input mrc_kind_t k, input logic [15:0] mo);
    case (k)
      K_RESET:  fix_mo = {`MRC_OP_RESET, `MRC_MA_RESET};
      K_ZQ:     fix_mo = {mo[15:8], `MRC_MA_ZQ};
      K_TENTER: fix_mo = {`MRC_OP_TENTER, `MRC_MA_TENTER};
      K_TREMAP: fix_mo = {`MRC_OP_TREMAP, `MRC_MA_TREMAP};
      K_TEXIT:  fix_mo = {`MRC_OP_TEXIT, `MRC_MA_TEXIT};
      default:  fix_mo = mo;
    endcase
  endfunction

  // ca words for one command, {rise, fall}
  function automatic logic [19:0] enc_ca(input mrc_kind_t k, input logic [7:0] ma,
                                         input logic [7:0] op);
    case (k)
      K_MRR:   enc_ca = {ma[5:0], 4'h8, 8'h00, ma[7:6]};
      K_TCAP:  enc_ca = {op[1:0], ma, ~op[1:0], ~ma};
      default: enc_ca = {ma[5:0], 4'h0, op, ma[7:6]};
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] zq_cyc(input logic [1:0] len);
    case (len)
      2'h1:    zq_cyc = CNT_W'(`MRC_TZQCS_CYC);
      2'h2:    zq_cyc = CNT_W'(`MRC_TZQCL_CYC);
      default: zq_cyc = CNT_W'(`MRC_TZQINIT_CYC);
    endcase
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [31:0] dq_s1_q, dq_s2_q;
  logic        gnt_s1_q, gnt_s2_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dq_s1_q  <= 32'h0000_0000;
      dq_s2_q  <= 32'h0000_0000;
      gnt_s1_q <= 1'b0;
      gnt_s2_q <= 1'b0;
    end else begin
      dq_s1_q  <= dq_in;
      dq_s2_q  <= dq_s1_q;
      gnt_s1_q <= zq_gnt;
      gnt_s2_q <= gnt_s1_q;
    end
  end

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  mrc_state_t           state_q;
  mrc_kind_t            kind_q;
  mrc_tphase_t          tphase_q;
  logic [CNT_W-1:0]     cnt_q;
  logic [7:0]           ma_q, op_q;
  logic [1:0]           zq_len_q;
  logic [`MRC_CMD_W-1:0] cmd_q;
  logic [1:0]           ctrl_q;
  logic [31:0]          rdata_q;
  logic                 err_q, sess_q, ap_wr_q;
  logic [7:0]           ap_addr_q;
  logic                 pat_ok, pat_done, fire, wr_cmd, launch;
  mrc_kind_t            l_kind;
  logic [15:0]          l_mo;

  assign l_kind = mrc_kind_t'(hwdata[`MRC_CMD_KIND_LSB +: 3]);
  assign l_mo   = fix_mo(l_kind, hwdata[15:0]);
  assign wr_cmd = ap_wr_q && (ap_addr_q == `MRC_OFF_CMD);
  assign launch = wr_cmd && (state_q == ST_IDLE) &&
                  cmd_ok(l_kind, hwdata[7:0], tphase_q, sess_q, banks_idle);
  assign fire   = (state_q == ST_ISSUE) && !((kind_q == K_TREMAP) && !cke);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      ap_wr_q   <= hsel && hready && htrans[1] && hwrite && (hsize == 3'h2);
      ap_addr_q <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          `MRC_OFF_CMD:   hrdata <= {10'h000, cmd_q};
          `MRC_OFF_STAT:  hrdata <= {24'h00_0000, zq_req, sess_q, tphase_q,
                                     pat_done, pat_ok, err_q, state_q != ST_IDLE};
          `MRC_OFF_CTRL:  hrdata <= {30'h0000_0000, ctrl_q};
          `MRC_OFF_RDATA: hrdata <= rdata_q;
          default:        hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q  <= '0;
      ctrl_q <= `MRC_CTRL_RST;
      err_q  <= 1'b0;
    end else begin
      if (wr_cmd)
        cmd_q <= hwdata[`MRC_CMD_W-1:0];
      if (ap_wr_q && (ap_addr_q == `MRC_OFF_CTRL))
        ctrl_q <= hwdata[1:0];
      // a refused order sets the flag; set wins over the clear
      if (wr_cmd && !launch)
        err_q <= 1'b1;
      else if (ap_wr_q && (ap_addr_q == `MRC_OFF_STAT) && hwdata[`MRC_ST_ERR])
        err_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q  <= ST_IDLE;
      cnt_q    <= '0;
      kind_q   <= K_MRW;
      ma_q     <= 8'h00;
      op_q     <= 8'h00;
      zq_len_q <= 2'h0;
      zq_req   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
          if (launch) begin
            kind_q   <= l_kind;
            ma_q     <= l_mo[7:0];
            op_q     <= l_mo[15:8];
            zq_len_q <= hwdata[`MRC_CMD_ZQ_LSB +: 2];
            if ((l_kind == K_ZQ) && (hwdata[`MRC_CMD_ZQ_LSB +: 2] != 2'h0)) begin
              state_q <= ST_ZQARB;
              zq_req  <= 1'b1;
            end else begin
              state_q <= ST_ISSUE;
            end
          end
        end
        ST_ZQARB: if (gnt_s2_q) state_q <= ST_ISSUE;
        ST_ISSUE: if (fire) begin
          if (is_rd(kind_q))
            state_q <= ST_RDLAT;
          else if ((kind_q == K_ZQ) && (zq_len_q != 2'h0))
            state_q <= ST_ZQ;
          else
            state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(`MRC_TMRW_CYC - 1)) state_q <= ST_IDLE;
        end
        ST_ZQ: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == zq_cyc(zq_len_q) - 1'b1) begin
            state_q <= ST_IDLE;
            zq_req  <= 1'b0;
          end
        end
        ST_RDLAT: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(RD_LAT - 1)) begin
            state_q <= ST_CAPT;
            cnt_q   <= '0;
          end
        end
        ST_CAPT: begin
          cnt_q <= cnt_q + 1'b1;
          if ((kind_q == K_TCAP) || (cnt_q == CNT_W'(`MRC_BURST - 1)))
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // training phase and read capture
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tphase_q <= TP_NONE;
      sess_q   <= 1'b0;
      rdata_q  <= 32'h0000_0000;
    end else begin
      if (fire) begin
        case (kind_q)
          K_TENTER: tphase_q <= TP_ENTERED;
          K_TREMAP: tphase_q <= TP_REMAPPED;
          K_TEXIT:  tphase_q <= TP_NONE;
          K_RESET:  tphase_q <= TP_NONE;
          default:  tphase_q <= tphase_q;
        endcase
        if ((kind_q == K_TENTER) || (kind_q == K_TREMAP))
          sess_q <= 1'b0;
      end
      if ((state_q == ST_CAPT) && (cnt_q == '0)) begin
        rdata_q <= dq_s2_q;
        if (kind_q == K_TCAP) sess_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // command/address pins
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cs_n    <= 1'b1;
      ca_rise <= 10'h000;
      ca_fall <= 10'h000;
    end else begin
      cs_n <= !fire;
      // ca holds between commands so the bus stays quiet
      if (fire) {ca_rise, ca_fall} <= enc_ca(kind_q, ma_q, op_q);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cke <= 1'b1;
    else if ((state_q == ST_ISSUE) && (kind_q == K_TREMAP))
      cke <= 1'b1;
    else if ((state_q == ST_ZQARB) || (state_q == ST_ZQ))
      cke <= 1'b1;
    else if (state_q == ST_IDLE)
      cke <= !(ctrl_q[`MRC_CTL_CKE_OFF] && (tphase_q != TP_NONE));
  end

  // ----------------------------------------
  // calibration pattern check
  // ----------------------------------------
  mrc_pat_chk #(.LANES(4)) u_pat (
    .clk      (hclk),
    .rst_n    (hresetn),
    .beat_vld ((state_q == ST_CAPT) && (kind_q == K_MRR) && is_cal(ma_q)),
    .beat_idx (cnt_q[2:0]),
    .pat_b    (ma_q == `MRC_MA_PAT_B),
    .x32      (ctrl_q[`MRC_CTL_X32]),
    .dq       (dq_s2_q),
    .ok       (pat_ok),
    .done     (pat_done)
  );

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_mrw_banks_idle: assert property (
    (launch && !is_rd(l_kind) && (tphase_q == TP_NONE)) |-> banks_idle)
    else $error("register write launched with banks active");
  a_cal_read_idle: assert property (
    (launch && (l_kind == K_MRR) && is_cal(hwdata[7:0])) |-> banks_idle)
    else $error("calibration read launched with banks active");
  a_nop_after_mrw: assert property (
    (!cs_n && (ca_rise[3:0] == 4'h0)) |=> cs_n [*2])
    else $error("command issued inside write command period");
  a_zq_quiet: assert property (
    (state_q == ST_ZQ) |-> (cke && zq_req && (cs_n || (cnt_q == '0))))
    else $error("activity or cke low during calibration");
  a_zq_grant: assert property (
    (fire && (kind_q == K_ZQ) && (zq_len_q != 2'h0)) |-> ($past(gnt_s2_q) && zq_req))
    else $error("calibration started without resistor grant");
  a_reset_code: assert property (
    (fire && (kind_q == K_RESET)) |=> (!cs_n && (ca_fall[9:2] == `MRC_OP_RESET)))
    else $error("reset write without fc opcode");
  a_remap_order: assert property (
    (fire && (kind_q == K_TREMAP)) |-> (sess_q && (tphase_q == TP_ENTERED)))
    else $error("remap write out of order");
  a_exit_order: assert property (
    (fire && (kind_q == K_TEXIT)) |-> (sess_q && (tphase_q == TP_REMAPPED)))
    else $error("training exit before both sessions");
  a_cke_remap: assert property (
    (fire && (kind_q == K_TREMAP)) |-> (cke ##1 (cke && !cs_n)))
    else $error("remap write issued without cke high first");

endmodule
`default_nettype wire

// [mrc_dev_model.sv]
// mrc_dev_model.sv: behavioural memory device answering mode register commands
`timescale 1ns/1ps
`default_nettype none
module mrc_dev_model #(
  parameter int LAT = 4
) (
  // command pins
  input  wire logic        clk,
  input  wire logic        cs_n,
  input  wire logic [9:0]  ca_rise,
  input  wire logic [9:0]  ca_fall,
  // scenario controls
  input  wire logic        x32,
  input  wire logic        bad,
  // data pins, one beat per clock
  output logic [31:0]      dq
);
  logic [7:0]  mr [0:255];
  logic [7:0]  ma, op, rma, pat, lane;
  logic [31:0] hold;
  logic        cal;
  int          tp, rdw, beat;

  initial begin
    foreach (mr[i]) mr[i] = 8'h00;
    tp = 0;
    rdw = 0;
    beat = 8;
    dq = 32'h0000_0000;
    hold = 32'h0000_0000;
  end

  // ----------------------------------------
  // command decode and data output
  // ----------------------------------------
  always @(posedge clk) begin
    ma = {ca_fall[1:0], ca_rise[9:4]};
    op = ca_fall[9:2];
    if (cs_n === 1'b0 && tp != 0) begin
      if (ca_rise == ca_fall && ca_rise == 10'h300) begin
        tp = 2;
      end else if (ca_rise == ca_fall && ca_rise == 10'h2A0) begin
        tp = 0;
      end else if (tp == 1) begin
        hold = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
          hold[2*i] = ca_rise[i];
          hold[2*i+1] = ca_fall[i];
          hold[8+2*i] = ca_rise[5+i];
          hold[9+2*i] = ca_fall[5+i];
        end
      end else begin
        hold = {22'h00_0000, ca_fall[9], ca_rise[9], 6'h00, ca_fall[4], ca_rise[4]};
      end
    end else if (cs_n === 1'b0 && ca_rise[3:0] == 4'h0) begin
      if (ma == 8'h3F) begin
        foreach (mr[i]) mr[i] = 8'h00;
        tp = 0;
      end else if (ma == 8'h29 && op == 8'hA4) begin
        tp = 1;
      end else if (ma != 8'h20 && ma != 8'h28 && ma != 8'h0A) begin
        mr[ma] = op;
      end
    end else if (cs_n === 1'b0 && ca_rise[3:0] == 4'h8) begin
      rma = ma;
      cal = (ma == 8'h20 || ma == 8'h28);
      pat = (ma == 8'h28) ? 8'hCC : 8'h55;
      rdw = LAT;
      beat = 0;
    end
    if (rdw > 0) rdw--;
    // strobes are not modelled; outside training, unused lines toggle every clock
    if (tp != 0) begin
      dq <= hold;
    end else if (rdw == 0 && beat < 8) begin
      lane = {8{pat[beat]}};
      if (!cal) dq <= (beat == 0) ? {~dq[31:8], mr[rma]} : ~dq;
      else if (x32) dq <= {lane, lane, lane, lane ^ {4'h0, bad, 3'h0}};
      else dq <= {~dq[31:16], lane, lane ^ {4'h0, bad, 3'h0}};
      beat++;
    end else begin
      dq <= ~dq;
    end
  end
endmodule
`default_nettype wire

// [mrc_ctrl_tb.sv]
// mrc_ctrl_tb.sv: self-checking testbench of the mode register controller
`timescale 1ns/1ps
`default_nettype none
`include "mrc_defines.svh"
module mrc_ctrl_tb;
  import mrc_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, cs_n, cke;
  logic        banks_idle, zq_req, zq_gnt, x32, bad, lcke;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, dq_in, d;
  logic [9:0]  lr, lf, r, ca_rise, ca_fall;
  int          failures = 0, compares = 0, npls = 0, zqcnt = 0, zqcke = 0, cyc = 0, n0;
  int          zqc [4] = '{0, `MRC_TZQCS_CYC, `MRC_TZQCL_CYC, `MRC_TZQINIT_CYC};

  mrc_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cs_n(cs_n), .cke(cke),
    .ca_rise(ca_rise), .ca_fall(ca_fall), .dq_in(dq_in), .banks_idle(banks_idle),
    .zq_req(zq_req), .zq_gnt(zq_gnt));
  // the controller samples dq through two sync stages inside its read latency
  mrc_dev_model #(.LAT(`MRC_RD_LAT - 2)) dev (.clk(hclk), .cs_n(cs_n), .ca_rise(ca_rise),
    .ca_fall(ca_fall), .x32(x32), .bad(bad), .dq(dq_in));

  always #12.5 hclk = ~hclk;

  // ----------------------------------------
  // pin monitor and timeout
  // ----------------------------------------
  always @(posedge hclk) begin
    cyc++;
    if (hresetn && cs_n === 1'b0) begin
      npls++;
      lr = ca_rise;
      lf = ca_fall;
      lcke = cke;
      zqcnt = (zq_req === 1'b1) ? 1 : 0;
    end else if (zq_req === 1'b1) zqcnt++;
    if (zq_req === 1'b1 && cke !== 1'b1) zqcke++;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge hclk);
    do begin
      xfer(1'b0, `MRC_OFF_STAT, 32'h0000_0000);
      n++;
    end while (d[0] !== 1'b0 && n < 300);
    if (d[0] !== 1'b0) begin
      failures++;
      $display("MISMATCH at %0t: controller stayed busy", $time);
    end
  endtask

  task automatic cmd(input mrc_kind_t k, input logic [7:0] ma, input logic [7:0] op,
                     input logic [1:0] zl);
    xfer(1'b1, `MRC_OFF_CMD, {10'h000, zl, 1'b0, k, op, ma});
    wait_idle();
  endtask

  task automatic err_chk(input logic e);
    xfer(1'b0, `MRC_OFF_STAT, 32'h0000_0000);
    chk({31'h0, d[1]}, {31'h0, e});
    xfer(1'b1, `MRC_OFF_STAT, 32'h0000_0002);
  endtask

  function automatic logic [19:0] enc(input logic [7:0] ma, input logic [7:0] op);
    return {op, ma[7:6], ma[5:0], 4'h0};
  endfunction

  function automatic logic [31:0] tmap(input logic [9:0] a, input logic [9:0] b, input logic rm);
    logic [31:0] m;
    m = 32'h0000_0000;
    if (rm) m = {22'h00_0000, b[9], a[9], 6'h00, b[4], a[4]};
    else for (int i = 0; i < 8; i++) m[2*i +: 2] = {b[i + (i > 3)], a[i + (i > 3)]};
    return m;
  endfunction

  task automatic print_verdict();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {banks_idle, zq_gnt, x32, bad} = 4'b1110;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({28'h0, hreadyout, hresp, cs_n, cke}, 32'h0000_000B);
    foreach (zqc[i]) begin
      xfer(1'b0, 8'h04 * i[7:0], 32'h0000_0000);
      chk(d, (i == 2) ? 32'h0000_0001 : 32'h0000_0000);
    end
    xfer(1'b0, 8'h10, 32'h0000_0000);
    chk(d, 32'h0000_0000);
    cmd(K_MRW, 8'hC3, 8'h5A, 2'h0);
    chk({12'h000, lf, lr}, {12'h000, enc(8'hC3, 8'h5A)});
    cmd(K_MRR, 8'hC3, 8'h00, 2'h0);
    xfer(1'b0, `MRC_OFF_RDATA, 32'h0000_0000);
    chk({24'h00_0000, d[7:0]}, 32'h0000_005A);
    cmd(K_MRW, 8'h20, 8'h00, 2'h0);
    for (int i = 0; i < 4; i++) begin
      x32 <= (i != 3);
      bad <= (i == 2);
      xfer(1'b1, `MRC_OFF_CTRL, {31'h0, i != 3});
      cmd(K_MRR, (i == 1) ? 8'h28 : 8'h20, 8'h00, 2'h0);
      xfer(1'b0, `MRC_OFF_RDATA, 32'h0000_0000);
      r = (i == 3) ? 10'h0FF : 10'h3FF;
      chk(d & {{16{r[9]}}, 16'hFFFF},
          (i == 1) ? 32'h0 : {{16{r[9]}}, 12'hFFF, (i == 2) ? 4'h7 : 4'hF});
      xfer(1'b0, `MRC_OFF_STAT, 32'h0000_0000);
      chk({30'h0, d[3:2]}, (i == 2) ? 32'h0000_0002 : 32'h0000_0003);
    end
    bad <= 1'b0;
    x32 <= 1'b1;
    xfer(1'b1, `MRC_OFF_CTRL, 32'h0000_0001);
    banks_idle <= 1'b0;
    n0 = npls;
    cmd(K_MRW, 8'h03, 8'h11, 2'h0);
    err_chk(1'b1);
    cmd(K_MRR, 8'h20, 8'h00, 2'h0);
    err_chk(1'b1);
    chk(npls - n0, 32'h0000_0000);
    cmd(K_MRR, 8'hC3, 8'h00, 2'h0);
    err_chk(1'b0);
    banks_idle <= 1'b1;
    cmd(K_RESET, 8'h3F, 8'hFC, 2'h0);
    chk({12'h000, lf, lr}, {12'h000, enc(8'h3F, 8'hFC)});
    cmd(K_MRR, 8'hC3, 8'h00, 2'h0);
    xfer(1'b0, `MRC_OFF_RDATA, 32'h0000_0000);
    chk({24'h00_0000, d[7:0]}, 32'h0000_0000);
    zq_gnt <= 1'b0;
    n0 = npls;
    xfer(1'b1, `MRC_OFF_CMD, {10'h000, 2'h1, 1'b0, K_ZQ, 8'hAB, 8'h0A});
    repeat (20) @(posedge hclk);
    xfer(1'b0, `MRC_OFF_STAT, 32'h0000_0000);
    chk({30'h0, d[7], d[0]}, 32'h0000_0003);
    chk(npls - n0, 32'h0000_0000);
    zq_gnt <= 1'b1;
    wait_idle();
    chk({12'h000, lf, lr}, {12'h000, enc(8'h0A, 8'hAB)});
    for (int i = 0; i < 4; i++) begin
      n0 = npls;
      cmd(K_ZQ, 8'h0A, 8'h5C + i[7:0], i[1:0]);
      chk({31'h0, zqcnt >= zqc[i]}, 32'h0000_0001);
      chk(npls - n0, 32'h0000_0001);
    end
    chk(zqcke, 32'h0000_0000);
    cmd(K_TREMAP, 8'h30, 8'hC0, 2'h0);
    err_chk(1'b1);
    cmd(K_TENTER, 8'h29, 8'hA4, 2'h0);
    chk({12'h000, lf, lr}, {12'h000, enc(8'h29, 8'hA4)});
    cmd(K_TEXIT, 8'h2A, 8'hA8, 2'h0);
    err_chk(1'b1);
    for (int i = 0; i < 2; i++) begin
      r = i ? 10'h210 : 10'h1A5;
      cmd(K_TCAP, r[7:0], {6'h00, r[9:8]}, 2'h0);
      xfer(1'b0, `MRC_OFF_RDATA, 32'h0000_0000);
      chk(d, tmap(r, ~r, i[0]));
      if (i == 0) begin
        xfer(1'b1, `MRC_OFF_CTRL, 32'h0000_0003);
        repeat (3) @(posedge hclk);
        chk({31'h0, cke}, 32'h0000_0000);
        cmd(K_TREMAP, 8'h30, 8'hC0, 2'h0);
        chk({11'h000, lcke, lf, lr}, {11'h001, enc(8'h30, 8'hC0)});
        cmd(K_TEXIT, 8'h2A, 8'hA8, 2'h0);
        err_chk(1'b1);
      end
    end
    cmd(K_TEXIT, 8'h2A, 8'hA8, 2'h0);
    chk({12'h000, lf, lr}, {12'h000, enc(8'h2A, 8'hA8)});
    xfer(1'b0, `MRC_OFF_STAT, 32'h0000_0000);
    chk({30'h0, d[5:4]}, 32'h0000_0000);
    print_verdict();
  end
endmodule
`default_nettype wire
